//--- src/acr_regs.sv
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Enable bit 15 powers the channel up; clear shuts it down.
// - Idle-stop bit 13 halts the comparator in Idle; clear keeps running unless another channel's bit is set.
// - Any channel's idle-stop bit disables all channels during Idle.
// - Bits 12-11 pick hysteresis: none, 15, 30 or 45 mV.
// - Bit 10 puts the digital filter in the output path or bypasses it.
// - Bit 9 clocks filter and stretcher from PWM clock, else system.
// - Bit 8 routes this channel's DAC to the shared output pin.
// - Bits 7-6 select positive input pin A, B, C or D.
// - Bit 5 takes the DAC reference from the external source.
// - Bit 4 applies hysteresis to falling edge, else rising edge.
// - Bit 3 reads the live comparator level after polarity.
// - Bit 2 scales the DAC reference by 1.8, else by 1.0.
// - Bit 1 inverts the comparator output for every downstream use.
// - Bit 0 picks half supply or internal full-scale, internal ref only.
// - Ten-bit code sets threshold as code times full-scale over 1024.
// - Unimplemented bits read zero and ignore writes.
// - Asynchronous-set stretcher makes each pulse at least three cycles.
// - Filter passes a new level after three stable filter-clock cycles.
// - In Sleep an asynchronous path still raises the wake request.

module acr_regs (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [acr_pkg::PADDR_W-1:0]    paddr_i,
  input  wire logic [31:0]                    pwdata_i,
  input  wire logic [3:0]                     pstrb_i,
  output var  logic                           pready_o,
  output var  logic [31:0]                    prdata_o,
  output var  logic                           pslverr_o,
  input  wire logic                           idle_mode_i,
  input  wire logic                           pwm_tick_i,
  input  wire logic [acr_pkg::NUM_CH-1:0]     comparator_raw_i,
  output var  logic [acr_pkg::NUM_CH-1:0]     channel_enable_o,
  output logic [acr_pkg::NUM_CH-1:0][1:0]     hysteresis_select_o,
  output logic [acr_pkg::NUM_CH-1:0]          hysteresis_polarity_o,
  output logic [acr_pkg::NUM_CH-1:0]          dac_output_enable_o,
  output logic [acr_pkg::NUM_CH-1:0][1:0]     input_select_o,
  output logic [acr_pkg::NUM_CH-1:0]          external_reference_enable_o,
  output logic [acr_pkg::NUM_CH-1:0]          dac_gain_select_o,
  output logic [acr_pkg::NUM_CH-1:0]          range_select_o,
  output logic [acr_pkg::NUM_CH-1:0][9:0]     reference_code_o,
  output var  logic [acr_pkg::NUM_CH-1:0]     comparator_event_o,
  output logic [acr_pkg::NUM_CH-1:0]          wake_o
);

  logic [15:0]                ctrl_r [acr_pkg::NUM_CH];
  logic [15:0]                ref_r  [acr_pkg::NUM_CH];
  logic [acr_pkg::NUM_CH-1:0] run_r;
  logic [acr_pkg::NUM_CH-1:0] run_nxt;
  logic [acr_pkg::NUM_CH-1:0] state;
  logic [acr_pkg::NUM_CH-1:0] filt_out;
  logic [acr_pkg::NUM_CH-1:0] tick_sel;
  logic                       any_stop;
  logic                       hit;
  logic                       wr_en;
  logic                       ch;
  logic                       is_ref;

  function automatic logic acr_hit(input logic [11:0] a);
    return (a & ~acr_pkg::MAP_MASK) == 12'h000;
  endfunction

  // Byte-lane merge; only the low two lanes hold register bits
  function automatic logic [15:0] acr_merge(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  strb,
                                            input logic [15:0] mask);
    logic [15:0] nv;
    nv = old;
    if (strb[0]) begin
      nv[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      nv[15:8] = wd[15:8];
    end
    return nv & mask;
  endfunction

  function automatic logic [15:0] acr_read(input logic [15:0] c,
                                           input logic [15:0] r,
                                           input logic        st,
                                           input logic        sel_ref);
    logic [15:0] v;
    v = c & acr_pkg::CTRL_WMASK;
    v[acr_pkg::BIT_STAT] = st;
    if (sel_ref) begin
      v = r & acr_pkg::REF_WMASK;
    end
    return v;
  endfunction

  assign hit    = acr_hit(paddr_i);
  assign ch     = paddr_i[acr_pkg::CH_BIT];
  assign is_ref = paddr_i[acr_pkg::REF_BIT];
  assign wr_en  = psel_i && penable_i && pready_o && pwrite_i && hit;

  // Zero-wait slave: ready comes up in the first access cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !hit;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i && hit) begin
      prdata_o <= {16'h0000, acr_read(ctrl_r[ch], ref_r[ch], state[ch],
                                       is_ref)};
    end else if (!psel_i) begin
      prdata_o <= 32'h0000_0000;
    end
  end

  // Reserved bits are never stored, so they read zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < acr_pkg::NUM_CH; i++) begin
        ctrl_r[i] <= acr_pkg::CTRL_RST;
        ref_r[i]  <= acr_pkg::REF_RST;
      end
    end else if (wr_en) begin
      if (is_ref) begin
        ref_r[ch] <= acr_merge(ref_r[ch], pwdata_i[15:0], pstrb_i[1:0],
                               acr_pkg::REF_WMASK);
      end else begin
        ctrl_r[ch] <= acr_merge(ctrl_r[ch], pwdata_i[15:0], pstrb_i[1:0],
                                acr_pkg::CTRL_WMASK);
      end
    end
  end

  // One idle-stop bit stops the whole group, keeps clock control simple
  always_comb begin
    any_stop = 1'b0;
    for (int i = 0; i < acr_pkg::NUM_CH; i++) begin
      any_stop = any_stop | ctrl_r[i][acr_pkg::BIT_ISTOP];
    end
    for (int i = 0; i < acr_pkg::NUM_CH; i++) begin
      run_nxt[i] = ctrl_r[i][acr_pkg::BIT_EN]
                   && !(idle_mode_i && any_stop);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_r <= '0;
    end else begin
      run_r <= run_nxt;
    end
  end

  assign channel_enable_o = run_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      comparator_event_o <= '0;
    end else begin
      comparator_event_o <= filt_out & run_r;
    end
  end

  for (genvar g = 0; g < acr_pkg::NUM_CH; g++) begin : ch_g
    acr_path_if u_path ();
    logic       pol_level;
    logic       stretched;

    // Polarity ahead of the stretcher, so every consumer sees it
    assign pol_level = run_r[g]
                       && (comparator_raw_i[g]
                           ^ ctrl_r[g][acr_pkg::BIT_POL]);
    assign tick_sel[g] = ctrl_r[g][acr_pkg::BIT_FCLK] ? pwm_tick_i
                                                       : 1'b1;

    acr_stretch u_stretch (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (pol_level),
      .tick_i (tick_sel[g]),
      .q_o    (stretched)
    );

    assign wake_o[g]        = stretched;
    assign u_path.run      = run_r[g];
    assign u_path.filt_en  = ctrl_r[g][acr_pkg::BIT_FLT];
    assign u_path.tick     = tick_sel[g];
    assign u_path.level_in = stretched;

    acr_filter u_filter (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .path  (u_path.flt)
    );

    assign state[g]    = u_path.state;
    assign filt_out[g] = u_path.filt_out;

    // Analog settings go straight from the stored bits
    assign hysteresis_select_o[g] =
      ctrl_r[g][acr_pkg::HYS_LSB +: 2];
    assign hysteresis_polarity_o[g] =
      ctrl_r[g][acr_pkg::BIT_HPOL];
    assign dac_output_enable_o[g] =
      ctrl_r[g][acr_pkg::BIT_DAC_OUTPUT_ENABLE];
    assign input_select_o[g] =
      ctrl_r[g][acr_pkg::INSEL_LSB +: 2];
    assign external_reference_enable_o[g] =
      ctrl_r[g][acr_pkg::BIT_EXT];
    assign dac_gain_select_o[g] =
      ctrl_r[g][acr_pkg::BIT_GAIN];
    // Range only matters while the external reference is off
    assign range_select_o[g] =
      ctrl_r[g][acr_pkg::BIT_RANGE];
    assign reference_code_o[g] =
      ref_r[g][acr_pkg::REF_W-1:0];
  end

  enable_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_r[0][acr_pkg::BIT_EN] |=> !channel_enable_o[0])
    else $error("channel stayed enabled with enable bit clear");

  idle_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_r[0][acr_pkg::BIT_EN] && !any_stop
    |=> channel_enable_o[0])
    else $error("channel stopped though no idle-stop bit set");

  idle_group_a: assert property (@(posedge clk_i) disable iff (rst_i)
    idle_mode_i && ctrl_r[1][acr_pkg::BIT_ISTOP]
    |=> channel_enable_o == '0)
    else $error("a channel ran in Idle with idle-stop set");

  rsvd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pready_o && psel_i && !pwrite_i
    |-> prdata_o[31:16] == 16'h0000 && !prdata_o[acr_pkg::BIT_RSV]
      && (!is_ref || prdata_o[15:10] == 6'h00))
    else $error("unimplemented bits read nonzero");

  status_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pready_o && psel_i && !pwrite_i && paddr_i == acr_pkg::OFS_CTRL0
    |-> prdata_o[acr_pkg::BIT_STAT] == $past(state[0]))
    else $error("status bit does not show comparator level");

  ref_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && paddr_i == acr_pkg::OFS_REF1 && pstrb_i[1:0] == 2'h3
    |=> reference_code_o[1] == $past(pwdata_i[9:0]))
    else $error("reference code write lost");

  event_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 comparator_event_o == $past(filt_out & run_r))
    else $error("event output does not follow filtered level");

  pol_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !run_r[0] [*4] |-> !comparator_event_o[0])
    else $error("disabled channel produced an event");

  idle_stop_c: cover property (@(posedge clk_i) disable iff (rst_i)
    idle_mode_i && any_stop ##1 channel_enable_o == '0);
  event_rise_c: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(comparator_event_o[0]));
  ctrl_write_c: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_en && !is_ref);
  unmapped_c: cover property (@(posedge clk_i) disable iff (rst_i)
    pslverr_o && psel_i && penable_i);

endmodule

`default_nettype wire

//--- src/acr_pkg.sv
package acr_pkg;

  localparam int unsigned NUM_CH = 2;
  localparam int unsigned PADDR_W = 12;

  // Register map, one 32-bit word each
  localparam logic [11:0] OFS_CTRL0 = 12'h000;
  localparam logic [11:0] OFS_REF0  = 12'h004;
  localparam logic [11:0] OFS_CTRL1 = 12'h008;
  localparam logic [11:0] OFS_REF1  = 12'h00c;
  localparam logic [11:0] MAP_MASK  = 12'h00c;
  localparam int unsigned CH_BIT    = 3;
  localparam int unsigned REF_BIT   = 2;

  // Control register fields
  localparam int unsigned BIT_EN    = 15;
  localparam int unsigned BIT_RSV   = 14;
  localparam int unsigned BIT_ISTOP = 13;
  localparam int unsigned HYS_LSB   = 11;
  localparam int unsigned BIT_FLT   = 10;
  localparam int unsigned BIT_FCLK  = 9;
  localparam int unsigned BIT_DAC_OUTPUT_ENABLE = 8;
  localparam int unsigned INSEL_LSB = 6;
  localparam int unsigned BIT_EXT   = 5;
  localparam int unsigned BIT_HPOL  = 4;
  localparam int unsigned BIT_STAT  = 3;
  localparam int unsigned BIT_GAIN  = 2;
  localparam int unsigned BIT_POL   = 1;
  localparam int unsigned BIT_RANGE = 0;
  localparam int unsigned REF_W     = 10;

  localparam logic [15:0] CTRL_WMASK = 16'hbff7;
  localparam logic [15:0] REF_WMASK  = 16'h03ff;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] REF_RST    = 16'h0000;

  // Minimum widths, in selected clock ticks
  localparam logic [1:0] STRETCH_TICKS = 2'h3;
  localparam logic [1:0] FILT_TICKS    = 2'h3;

endpackage

//--- src/acr_path_if.sv
`timescale 1ns/10ps
`default_nettype none

interface acr_path_if;
  logic run;
  logic filt_en;
  logic tick;
  logic level_in;
  logic state;
  logic filt_out;

  modport ctl (output run, filt_en, tick, level_in, input state, filt_out);
  modport flt (input run, filt_en, tick, level_in, output state, filt_out);
endinterface

`default_nettype wire

//--- src/acr_stretch.sv
`timescale 1ns/10ps
`default_nettype none

module acr_stretch (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic tick_i,
  output var  logic q_o
);
  logic [1:0] cnt_r;

  // Async set catches pulses shorter than a clock, also in Sleep
  always_ff @(posedge clk_i or posedge rst_i or posedge set_i) begin
    if (rst_i) begin
      q_o   <= 1'b0;
      cnt_r <= 2'h0;
    end else if (set_i) begin
      q_o   <= 1'b1;
      cnt_r <= 2'h0;
    end else if (q_o && tick_i) begin
      if (cnt_r == acr_pkg::STRETCH_TICKS - 2'h1) begin
        q_o   <= 1'b0;
        cnt_r <= 2'h0;
      end else begin
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end

  stretch_min_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(q_o) |=> q_o [*2])
    else $error("stretched pulse shorter than three cycles");

endmodule

`default_nettype wire

//--- src/acr_filter.sv
`timescale 1ns/10ps
`default_nettype none

module acr_filter (
  input  wire logic clk_i,
  input  wire logic rst_i,
  acr_path_if.flt   path
);
  logic       s1_r;
  logic       s2_r;
  logic       out_r;
  logic [1:0] cnt_r;

  // Stretcher output is set asynchronously, so resynchronise it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= path.level_in;
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_r <= 1'b0;
      cnt_r <= 2'h0;
    end else if (!path.run) begin
      out_r <= 1'b0;
      cnt_r <= 2'h0;
    end else if (!path.filt_en) begin
      out_r <= s2_r;
      cnt_r <= 2'h0;
    end else if (s2_r == out_r) begin
      cnt_r <= 2'h0;
    end else if (path.tick) begin
      if (cnt_r == acr_pkg::FILT_TICKS - 2'h1) begin
        out_r <= s2_r;
        cnt_r <= 2'h0;
      end else begin
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end

  assign path.state    = s2_r;
  assign path.filt_out = out_r;

  filter_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(out_r) && $past(path.run) && $past(path.filt_en)
      && $past(path.filt_en, 3)
    |-> $past(s2_r, 1) == out_r && $past(s2_r, 2) == out_r
      && $past(s2_r, 3) == out_r)
    else $error("filter passed a level held under three cycles");

  filter_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    path.run && !path.filt_en |=> out_r == $past(s2_r))
    else $error("bypassed filter did not follow its input");

endmodule

`default_nettype wire

//--- tb/acr_analog_model.sv
`timescale 1ns/10ps
`default_nettype none

// Ideal comparator: hysteresis is not modelled, levels are in millivolts
module acr_analog_model #(
  parameter int HALF_FS = 1650,
  parameter int INT_FS  = 1200,
  parameter int EXT_FS  = 1000
) (
  input  wire logic [1:0]           en_i,
  input  wire logic [1:0][1:0]      sel_i,
  input  wire logic [1:0]           ext_i,
  input  wire logic [1:0]           range_i,
  input  wire logic [1:0]           gain_i,
  input  wire logic [1:0][9:0]      code_i,
  input  wire logic [1:0][3:0][9:0] pin_i,
  output var  logic [1:0]           raw_o
);
  int fs;
  int thr;

  always_comb begin
    fs = 0;
    thr = 0;
    for (int c = 0; c < 2; c++) begin
      fs = ext_i[c] ? EXT_FS : (range_i[c] ? HALF_FS : INT_FS);
      thr = int'(code_i[c]) * fs / 1024;
      if (gain_i[c]) begin
        thr = thr * 18 / 10;
      end
      raw_o[c] = en_i[c] && (int'(pin_i[c][sel_i[c]]) > thr);
    end
  end
endmodule

`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic                  clk_i = 0, rst_i = 1, psel = 0, penable = 0;
  logic                  pwrite = 0, idle = 0, tick = 0, pready, pslverr;
  logic [11:0]           paddr = '0;
  logic [31:0]           pwdata = '0, prdata;
  logic [3:0]            pstrb = '0;
  logic [1:0]            en, dac_output_enable, ext, hpol, gain, rng, ev, wake, raw;
  logic [1:0][1:0]       hys, isel;
  logic [1:0][9:0]       code;
  logic [1:0][3:0][9:0]  pin = '0;
  logic [15:0]           ctrl_m [2], ref_m [2];
  int                    errors = 0, comparisons = 0, seed = 32'h3343, tc = 0;

  always #5 clk_i = ~clk_i;
  // PWM clock as a tick every fourth cycle
  always @(posedge clk_i) begin
    tc <= tc + 1;
    tick <= (tc % 4 == 3);
  end

  acr_regs acr_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .idle_mode_i(idle),
    .pwm_tick_i(tick), .comparator_raw_i(raw), .channel_enable_o(en),
    .hysteresis_select_o(hys), .hysteresis_polarity_o(hpol),
    .dac_output_enable_o(dac_output_enable), .input_select_o(isel),
    .external_reference_enable_o(ext), .dac_gain_select_o(gain),
    .range_select_o(rng), .reference_code_o(code),
    .comparator_event_o(ev), .wake_o(wake));

  acr_analog_model acr_analog_model_inst (.en_i(en), .sel_i(isel),
    .ext_i(ext), .range_i(rng), .gain_i(gain), .code_i(code), .pin_i(pin),
    .raw_o(raw));

  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_i);
    penable <= 1;
    // Read before the edge's flop updates land: the values the edge samples
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(int c, bit r, logic [15:0] d, logic [3:0] s);
    logic [31:0] rd;
    logic        er;
    logic [15:0] m;
    m = (r ? 16'h03ff : 16'hbff7) & {{8{s[1]}}, {8{s[0]}}};
    apb(1, 12'(c * 8 + r * 4), {16'h0, d}, s, rd, er);
    if (r) ref_m[c] = (ref_m[c] & ~m) | (d & m);
    else ctrl_m[c] = (ctrl_m[c] & ~m) | (d & m);
    chk("wr_err", 0, er);
  endtask

  task automatic rdchk(int c, bit r, logic st);
    logic [31:0] rd;
    logic        er;
    apb(0, 12'(c * 8 + r * 4), 32'h0, 4'h0, rd, er);
    chk("rd", r ? ref_m[c] : (ctrl_m[c] | (16'(st) << 3)), rd);
    chk("rd_err", 0, er);
  endtask

  task automatic wait_ev(int c, logic v, output int n);
    n = 0;
    while (ev[c] !== v && n < 100) begin
      @(negedge clk_i);
      n++;
    end
  endtask

  initial begin
    #500000;
    errors++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] rd;
    logic        er;
    logic [15:0] d;
    int          c, r, n;
    ctrl_m = '{default: '0};
    ref_m = '{default: '0};
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 4; i++) rdchk(i / 2, i % 2, 0);
    repeat (40) begin
      c = $random(seed) & 1;
      r = $random(seed) & 1;
      d = 16'($random(seed));
      d[15] = 0;
      if (c == 1) d[8] = 0;
      wr(c, r, d, 4'($random(seed)));
      rdchk(c, r, 0);
      chk("fields", {ctrl_m[c][12:11], ctrl_m[c][4], ctrl_m[c][8],
          ctrl_m[c][7:6], ctrl_m[c][5], ctrl_m[c][2], ctrl_m[c][0],
          ref_m[c][9:0]}, {hys[c], hpol[c], dac_output_enable[c], isel[c], ext[c],
          gain[c], rng[c], code[c]});
    end
    for (int i = 0; i < 4; i++) wr(i / 2, i % 2, 16'h0, 4'hf);
    foreach (paddr[k]) begin
      if (k == 2 || k == 3) continue;
      apb(1, 12'h1 << k, 32'hffff, 4'hf, rd, er);
      chk("bad_wr_err", 1, er);
      apb(0, 12'h1 << k, 32'h0, 4'h0, rd, er);
      chk("bad_rd_err", 1, er);
      chk("bad_rd", 0, rd);
    end
    rdchk(0, 0, 0);
    wr(0, 0, 16'h8000, 4'hf);
    wr(1, 0, 16'ha000, 4'hf);
    repeat (3) @(negedge clk_i);
    chk("enable", 2'b11, en);
    @(posedge clk_i) idle <= 1;
    repeat (3) @(negedge clk_i);
    chk("idle_stop", 2'b00, en);
    @(posedge clk_i) idle <= 0;
    wr(1, 0, 16'h8000, 4'hf);
    @(posedge clk_i) idle <= 1;
    repeat (3) @(negedge clk_i);
    chk("idle_run", 2'b11, en);
    @(posedge clk_i) idle <= 0;
    // Threshold 512/1024 of 1650 mV on pin C
    wr(0, 1, 16'd512, 4'hf);
    wr(0, 0, 16'h8081, 4'hf);
    @(posedge clk_i) pin[0][2] <= 10'd900;
    wait_ev(0, 1, n);
    chk("bypass_fast", 1, n < 8);
    rdchk(0, 0, 1);
    wr(0, 0, 16'h8083, 4'hf);
    wait_ev(0, 0, n);
    chk("inverted", 1, n < 20);
    rdchk(0, 0, 0);
    wr(0, 0, 16'h8681, 4'hf);
    wait_ev(0, 1, n);
    chk("filter_slow", 1, n >= 8 && n < 60);
    wr(0, 0, 16'h8081, 4'hf);
    @(posedge clk_i) pin[0][2] <= 10'd0;
    wait_ev(0, 0, n);
    chk("low", 1, n < 20);
    @(posedge clk_i) pin[0][2] <= 10'd900;
    @(posedge clk_i) pin[0][2] <= 10'd0;
    #1 chk("wake_async", 1, wake[0]);
    n = 0;
    while (wake[0] === 1'b1 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    chk("stretch", 1, n >= 3 && n < 50);
    tally_and_finish();
  end
endmodule

`default_nettype wire
